// ===== rtl/field_pair_cfg.svh
`ifndef FIELD_PAIR_CFG_SVH
`define FIELD_PAIR_CFG_SVH

// Clock rate
`define CLK_KHZ 40000
// Times in ms
`define SCAN_PERIOD_MS 40
`define BASE_TIMEOUT_MS 80
`define EXT_TIMEOUT_MS 40
`define REACTION_MS 80

// Register byte offsets and control reset value
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define CTRL_RESET 4'h0

// Control fields
`define CTRL_MODE_LSB 0
`define CTRL_WARN_BIT 2
`define CTRL_CFG_BIT 3

// Pair masks
`define FOUR_MASK 8'h03
`define PAIR1_MASK 8'h01
`define EVAL_MASK 8'h7F

`endif

// ===== rtl/field_pair_pkg.sv
package field_pair_pkg;

    typedef enum logic [1:0] {MODE_BASE, MODE_EXT, MODE_FOUR} mode_type;

    typedef enum logic [1:0] {ST_START, ST_RUN, ST_ERROR} state_type;

    typedef struct packed {
        logic cfg;
        logic warn_en;
        mode_type mode;
    } ctrl_type;

    typedef struct packed {
        logic valid;
        logic start_ok;
        logic [7:0] mask;
    } decode_type;

endpackage : field_pair_pkg

// ===== rtl/field_pair_selector.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "field_pair_cfg.svh"
module field_pair_selector #(
    parameter logic [21:0] SCAN_CYCLES = 22'(`SCAN_PERIOD_MS * `CLK_KHZ),
    parameter logic [21:0] BASE_CYCLES = 22'(`BASE_TIMEOUT_MS * `CLK_KHZ),
    parameter logic [21:0] EXT_CYCLES = 22'(`EXT_TIMEOUT_MS * `CLK_KHZ)
) (
    input wire logic pclk, // APB clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic pair_select_in_1, // Select input 1
    input wire logic pair_select_in_2, // Select input 2
    input wire logic pair_select_in_3, // Select input 3
    input wire logic pair_select_in_4, // Select input 4
    input wire logic [7:0] near_hit, // Object in near field per pair
    input wire logic [7:0] far_hit, // Object in far field per pair
    input wire logic device_warning, // Device warning level
    output logic switch_out_1, // Switching output 1, on when clear
    output logic switch_out_2, // Switching output 2, on when clear
    output logic alarm_out_1, // Alarm output 1, high when active
    output logic alarm_out_2, // Alarm output 2, high when active
    output logic error_out, // Latched error state
    output logic [7:0] field_pair_tag // Active pairs, one bit each
);
    logic [3:0] sel_meta_r;
    logic [3:0] code_s_r;
    logic [3:0] code_prev_r;
    field_pair_pkg::ctrl_type ctrl_r;
    field_pair_pkg::ctrl_type ctrl_nxt;
    field_pair_pkg::state_type state_r;
    field_pair_pkg::state_type state_nxt;
    field_pair_pkg::decode_type dec;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [21:0] cnt_r;
    logic [21:0] cnt_nxt;
    logic [21:0] limit;
    logic bad;
    logic err_set;
    logic tick;
    logic four;
    logic run;
    logic [7:0] vn_r;
    logic [7:0] vn_nxt;
    logic [7:0] vf_r;
    logic [7:0] vf_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt;
    logic pslverr_nxt;
    logic wr_ctrl;
    logic setup;
    logic addr_hit;

    pulse_divider #(
        .WIDTH(22),
        .PERIOD(SCAN_CYCLES)
    ) scan_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    pair_decoder decoder (
        .mode(ctrl_r.mode),
        .code(code_s_r),
        .dec(dec)
    );

    // Input synchroniser, first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_meta_r <= 4'h0;
            code_s_r <= 4'h0;
            code_prev_r <= 4'h0;
        end
        else
        begin
            sel_meta_r <= {pair_select_in_1, pair_select_in_2, pair_select_in_3, pair_select_in_4};
            code_s_r <= sel_meta_r;
            code_prev_r <= code_s_r;
        end
    end

    // APB slave, one wait-free access phase
    always_comb
    begin
        setup = psel && !penable;
        addr_hit = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS);
        pready_nxt = setup;
        pslverr_nxt = setup && !addr_hit;
        prdata_nxt = 32'h0000_0000;
        if (setup && !pwrite)
        begin
            if (paddr == `CTRL_OFS)
                prdata_nxt = {28'h0000000, ctrl_r};
            else if (paddr == `STATUS_OFS)
                prdata_nxt = {16'h0000, code_s_r, |vf_r, |vn_r, run, error_out, mask_r};
        end
        wr_ctrl = psel && penable && pwrite && pready && (paddr == `CTRL_OFS);
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt.cfg = pwdata[`CTRL_CFG_BIT];
            ctrl_nxt.warn_en = pwdata[`CTRL_WARN_BIT];
            // Variant only changes in a write that sets configuring, or while configuring
            if (pwdata[`CTRL_CFG_BIT] || ctrl_r.cfg)
                ctrl_nxt.mode = field_pair_pkg::mode_type'(pwdata[`CTRL_MODE_LSB +: 2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= field_pair_pkg::ctrl_type'(`CTRL_RESET);
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // Selection state and invalid-code timer
    always_comb
    begin
        four = (ctrl_r.mode == field_pair_pkg::MODE_FOUR);
        limit = (ctrl_r.mode == field_pair_pkg::MODE_EXT) ? EXT_CYCLES : BASE_CYCLES;
        bad = !dec.valid || ((state_r == field_pair_pkg::ST_START) && !dec.start_ok);
        cnt_nxt = 22'h000000;
        // A variant change restarts the timer, so a count taken against the old limit never overshoots the new one
        if (!four && bad && (code_s_r == code_prev_r) && !ctrl_r.cfg && (ctrl_nxt.mode == ctrl_r.mode))
            cnt_nxt = (cnt_r == limit) ? cnt_r : cnt_r + 22'h000001;
        err_set = !four && bad && !ctrl_r.cfg && (cnt_r == limit);
        state_nxt = state_r;
        mask_nxt = mask_r;
        unique case (state_r)
            field_pair_pkg::ST_START:
            begin
                mask_nxt = 8'h00;
                if (err_set)
                    state_nxt = field_pair_pkg::ST_ERROR;
                else if (tick && !bad && !ctrl_r.cfg)
                begin
                    state_nxt = field_pair_pkg::ST_RUN;
                    mask_nxt = dec.mask;
                end
            end
            field_pair_pkg::ST_RUN:
            begin
                if (err_set)
                    state_nxt = field_pair_pkg::ST_ERROR;
                else if (ctrl_r.cfg)
                    state_nxt = field_pair_pkg::ST_START;
                else if (!bad)
                    mask_nxt = dec.mask;
            end
            field_pair_pkg::ST_ERROR:
            begin
                mask_nxt = 8'h00;
            end
        endcase
        // Old selection must not outlive its table, or a two-pair mask would run in the extended variant
        if (ctrl_nxt.mode != ctrl_r.mode)
        begin
            mask_nxt = 8'h00;
            if (state_nxt == field_pair_pkg::ST_RUN)
                state_nxt = field_pair_pkg::ST_START;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= field_pair_pkg::ST_START;
            mask_r <= 8'h00;
            cnt_r <= 22'h000000;
        end
        else
        begin
            state_r <= state_nxt;
            mask_r <= mask_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Field evaluation once per scan
    always_comb
    begin
        run = (state_r == field_pair_pkg::ST_RUN) && !ctrl_r.cfg;
        vn_nxt = vn_r;
        vf_nxt = vf_r;
        if (!run)
        begin
            vn_nxt = 8'h00;
            vf_nxt = 8'h00;
        end
        else if (tick)
        begin
            // Pair eight fields are empty, so never evaluated
            vn_nxt = near_hit & mask_r & `EVAL_MASK;
            vf_nxt = far_hit & mask_r & `EVAL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vn_r <= 8'h00;
            vf_r <= 8'h00;
            switch_out_1 <= 1'b0;
            switch_out_2 <= 1'b0;
            alarm_out_1 <= 1'b0;
            alarm_out_2 <= 1'b0;
            error_out <= 1'b0;
            field_pair_tag <= 8'h00;
        end
        else
        begin
            vn_r <= vn_nxt;
            vf_r <= vf_nxt;
            switch_out_1 <= run && (four ? !vn_r[0] : ~|vn_r);
            switch_out_2 <= run && (four ? !vn_r[1] : ~|vf_r);
            alarm_out_1 <= ctrl_r.cfg || (run && ((four ? vf_r[0] : |vf_r) ||
                (ctrl_r.warn_en && device_warning)));
            alarm_out_2 <= ctrl_r.cfg || (run && (four ? vf_r[1] : |vf_r));
            error_out <= (state_r == field_pair_pkg::ST_ERROR);
            field_pair_tag <= mask_r;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    startup_off_a: assert property ((state_r == field_pair_pkg::ST_START) |=>
        (!switch_out_1 && !switch_out_2 && (alarm_out_1 == $past(ctrl_r.cfg))))
        else $error("output active during start-up");
    config_alarm_a: assert property (ctrl_r.cfg |=> (alarm_out_1 && alarm_out_2 && !switch_out_1))
        else $error("alarms not active while configuring");
    error_latch_a: assert property ((state_r == field_pair_pkg::ST_ERROR) |=>
        (state_r == field_pair_pkg::ST_ERROR) ##1 error_out)
        else $error("error state not latched");
    timeout_err_a: assert property (err_set |=> (state_r == field_pair_pkg::ST_ERROR))
        else $error("timeout did not raise error");
    ext_timeout_a: assert property (((ctrl_r.mode == field_pair_pkg::MODE_EXT) && cnt_r != 22'h000000)
        |-> (cnt_r <= EXT_CYCLES))
        else $error("extended invalid time exceeded");
    base_two_a: assert property ((ctrl_r.mode == field_pair_pkg::MODE_BASE) |->
        (($countones(mask_r) <= 2) && (mask_r[7:4] == 4'h0)))
        else $error("base variant mask too wide");
    ext_single_a: assert property (((ctrl_r.mode == field_pair_pkg::MODE_EXT) &&
        (state_r == field_pair_pkg::ST_RUN)) |-> $onehot(mask_r))
        else $error("extended variant not single pair");
    four_fixed_a: assert property ((four && (state_r == field_pair_pkg::ST_RUN) && !ctrl_r.cfg) |->
        ((mask_r == `FOUR_MASK) && (cnt_r == 22'h000000)))
        else $error("four-field mode followed the inputs");
    pair8_empty_a: assert property ((tick && run && mask_r[7] && near_hit[7] && far_hit[7]) |=>
        (!vn_r[7] && !vf_r[7]))
        else $error("pair eight reported a violation");
    scan_viol_a: assert property ((tick && run && |(near_hit & mask_r & `EVAL_MASK) && !four) |=>
        ##1 !switch_out_1)
        else $error("violation did not switch off");
    pair12_decode_a: assert property (((ctrl_r.mode == field_pair_pkg::MODE_BASE) && run &&
        (code_s_r == 4'hC)) |=> (mask_r == 8'h03))
        else $error("code 1100 not decoded to pairs one and two");
    apb_ready_a: assert property ((psel && !penable) |=> (pready && (pslverr == !$past(addr_hit))))
        else $error("no ready in access phase");

    run_enter_c: cover property ((state_r == field_pair_pkg::ST_START) ##1 (state_r == field_pair_pkg::ST_RUN));
    error_enter_c: cover property ($rose(state_r == field_pair_pkg::ST_ERROR));
    changeover_c: cover property (run && (mask_nxt != mask_r));
    four_viol_c: cover property (four && run && vf_r[1]);
endmodule : field_pair_selector

// ===== rtl/pair_decoder.sv
`timescale 1ns/1ps
`include "field_pair_cfg.svh"
module pair_decoder (
    input field_pair_pkg::mode_type mode, // Configuration variant
    input wire logic [3:0] code, // {in_1,in_2,in_3,in_4}
    output field_pair_pkg::decode_type dec // Decoded pairs
);
    always_comb
    begin
        dec = '0;
        unique case (mode)
            field_pair_pkg::MODE_FOUR:
            begin
                dec = '{valid: 1'b1, start_ok: 1'b1, mask: `FOUR_MASK};
            end
            field_pair_pkg::MODE_EXT:
            begin
                dec.valid = 1'b1;
                dec.start_ok = 1'b1;
                unique case (code)
                    4'h0, 4'h8: dec.mask = 8'h01;
                    4'h4: dec.mask = 8'h02;
                    4'h2: dec.mask = 8'h04;
                    4'h1: dec.mask = 8'h08;
                    4'hE: dec.mask = 8'h10;
                    4'hD: dec.mask = 8'h20;
                    4'hB: dec.mask = 8'h40;
                    4'h7:
                    begin
                        dec.mask = 8'h80;
                        dec.start_ok = 1'b0;
                    end
                    default:
                    begin
                        dec.valid = 1'b0;
                        dec.start_ok = 1'b0;
                    end
                endcase
            end
            default:
            begin
                // Base table; the unused mode code falls back here
                dec.valid = ($countones(code) <= 2);
                dec.start_ok = dec.valid;
                if (code == 4'h0)
                    dec.mask = `PAIR1_MASK;
                else if (dec.valid)
                    dec.mask = {4'h0, code[0], code[1], code[2], code[3]};
            end
        endcase
    end
endmodule : pair_decoder

// ===== rtl/pulse_divider.sv
`timescale 1ns/1ps
module pulse_divider #(
    parameter int WIDTH = 22,
    parameter logic [WIDTH-1:0] PERIOD = 22'h186A00
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    output logic tick // One-cycle pulse per period
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = (cnt_r == PERIOD - 1'b1);
        cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule : pulse_divider

// ===== verification/field_pair_selector_test.sv
`timescale 1ns/1ps
module field_pair_selector_test;
    typedef struct packed {logic sel; logic [32:0] m; logic [32:0] v;} exp_type;
    localparam int SC = 20;
    localparam int BC = 40;
    localparam int EC = 20;
    logic pclk, presetn, psel, penable, pwrite, slow, look, warn, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, s1, s2, s3, s4, sw1, sw2, al1, al2, err;
    logic [3:0] code_want;
    logic [7:0] near, far, tag, pm, nm;
    logic [32:0] got;
    exp_type q[$];
    exp_type e;
    int error_cnt, compares, k, c;
    field_pair_selector #(.SCAN_CYCLES(22'(SC)), .BASE_CYCLES(22'(BC)), .EXT_CYCLES(22'(EC))) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pair_select_in_1(s1), .pair_select_in_2(s2), .pair_select_in_3(s3), .pair_select_in_4(s4),
        .near_hit(near), .far_hit(far), .device_warning(warn), .switch_out_1(sw1), .switch_out_2(sw2),
        .alarm_out_1(al1), .alarm_out_2(al2), .error_out(err), .field_pair_tag(tag));
    select_ctrl_model u_ctrl (.pclk(pclk), .code_want(code_want), .slow(slow), .pair_select_in_1(s1),
        .pair_select_in_2(s2), .pair_select_in_3(s3), .pair_select_in_4(s4));
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_cyc
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic expect_val(input logic s, input logic [32:0] m, input logic [32:0] v);
        q.push_back(exp_type'{s, m, v});
        look <= 1'b1;
        @(posedge pclk);
        look <= 1'b0;
        @(posedge pclk);
    endtask : expect_val
    // Monitor takes the oldest note when the driver flags a result
    always @(posedge pclk)
    begin
        if (look === 1'b1 && q.size() > 0)
        begin
            e = q.pop_front();
            got = e.sel ? {se, rd} : {20'h0, err, al2, al1, sw2, sw1, tag};
            compares++;
            if (((got ^ e.v) & e.m) !== 33'h0)
            begin
                error_cnt++;
                $display("BAD at %0t: got %h expected %h mask %h", $time, got, e.v, e.m);
            end
        end
    end
    function automatic logic [32:0] outs(input logic [1:0] mode, input logic [7:0] m, input logic we);
        logic an;
        logic af;
        an = |(near & m & 8'h7F);
        af = |(far & m & 8'h7F);
        if (mode == 2'h2)
            return {20'h0, 1'b0, far[1], far[0] | (we & warn), ~near[1], ~near[0], 8'h03};
        return {20'h0, 1'b0, af, af | (we & warn), ~af, ~an, m};
    endfunction : outs
    // Zero means invalid; in_1 is bit 3 of the code and selects pair one
    function automatic logic [7:0] dec(input logic [1:0] mode, input logic [3:0] x);
        if (x == 4'h0 || x == 4'h8)
            return 8'h01;
        if ($countones(x) == 1 || (mode == 2'h0 && $countones(x) == 2))
            return {4'h0, x[0], x[1], x[2], x[3]};
        if (mode == 2'h1 && $countones(x) == 3)
            return x == 4'hE ? 8'h10 : x == 4'hD ? 8'h20 : x == 4'hB ? 8'h40 : 8'h80;
        return 8'h00;
    endfunction : dec
    task automatic do_reset();
        presetn <= 1'b0;
        wait_cyc(2);
        presetn <= 1'b1;
        code_want <= 4'h0;
        wait_cyc(1);
    endtask : do_reset
    task automatic set_mode(input logic [1:0] mode, input logic we);
        // Valid start code first, or the invalid timer trips once configuring ends
        code_want <= 4'h0;
        apb(1'b1, 12'h000, {28'h0, 1'b1, we, mode});
        wait_cyc(2);
        expect_val(1'b0, 33'h1F00, 33'h0C00);
        apb(1'b1, 12'h000, {28'h0, 1'b0, we, mode});
        apb(1'b0, 12'h000, 32'h0);
        expect_val(1'b1, 33'h1FFFFFFFF, {29'h0, we, mode});
        wait_cyc(SC + 6);
    endtask : set_mode
    task automatic code_sweep(input logic [1:0] mode);
        pm = 8'h01;
        for (c = 0; c < 16; c++)
        begin
            code_want <= 4'(c);
            near <= 8'($urandom);
            far <= 8'($urandom);
            warn <= 1'($urandom);
            nm = dec(mode, 4'(c));
            if (nm == 8'h00)
            begin
                wait_cyc(8);
                expect_val(1'b0, 33'h00FF, {25'h0, pm});
            end
            else
            begin
                pm = nm;
                wait_cyc(SC + 6);
                expect_val(1'b0, 33'h1FFF, outs(mode, pm, mode[0]));
            end
        end
    endtask : code_sweep
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    initial
    begin
        #(25ns * 20000);
        error_cnt++;
        $display("BAD at %0t: watchdog expired", $time);
        test_done();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, slow, look, warn, se} = 8'h00;
        {paddr, pwdata, rd, code_want, near, far} = 0;
        error_cnt = 0;
        compares = 0;
        k = $urandom(13131);
        wait_cyc(2);
        presetn <= 1'b1;
        wait_cyc(1);
        expect_val(1'b0, 33'h1FFF, 33'h0);
        apb(1'b0, 12'h000, 32'h0);
        expect_val(1'b1, 33'h1FFFFFFFF, 33'h0);
        apb(1'b0, 12'h010, 32'h0);
        expect_val(1'b1, 33'h1FFFFFFFF, {1'b1, 32'h0});
        $display("test reset done");
        set_mode(2'h0, 1'b0);
        code_sweep(2'h0);
        $display("test base done");
        set_mode(2'h1, 1'b1);
        code_sweep(2'h1);
        code_want <= 4'hE;
        wait_cyc(SC + 6);
        slow <= 1'b1;
        code_want <= 4'h1;
        // Four slow steps, then a full scan with the final pair
        wait_cyc(2 * SC + 6);
        expect_val(1'b0, 33'h1FFF, outs(2'h1, 8'h08, 1'b1));
        slow <= 1'b0;
        $display("test extended done");
        set_mode(2'h2, 1'b1);
        for (c = 0; c < 4; c++)
        begin
            code_want <= 4'($urandom);
            near <= 8'($urandom);
            far <= 8'($urandom);
            warn <= 1'($urandom);
            wait_cyc(SC + 6);
            expect_val(1'b0, 33'h1FFF, outs(2'h2, 8'h03, 1'b1));
        end
        $display("test four field done");
        do_reset();
        wait_cyc(SC + 6);
        code_want <= 4'hF;
        wait_cyc(BC - 4);
        code_want <= 4'h7;
        wait_cyc(BC - 4);
        expect_val(1'b0, 33'h1000, 33'h0);
        wait_cyc(10);
        expect_val(1'b0, 33'h1F00, 33'h1000);
        code_want <= 4'h0;
        wait_cyc(SC + 6);
        expect_val(1'b0, 33'h1F00, 33'h1000);
        do_reset();
        set_mode(2'h1, 1'b0);
        code_want <= 4'hC;
        wait_cyc(EC + 8);
        expect_val(1'b0, 33'h1000, 33'h1000);
        apb(1'b0, 12'h004, 32'h0);
        expect_val(1'b1, {1'b1, 32'h100}, {1'b0, 32'h100});
        $display("test error done");
        test_done();
    end
endmodule : field_pair_selector_test

// ===== verification/select_ctrl_model.sv
`timescale 1ns/1ps
module select_ctrl_model (
    input wire logic pclk, // Clock
    input wire logic [3:0] code_want, // Wanted code, bit 3 is input 1
    input wire logic slow, // Change one bit every four cycles
    output logic pair_select_in_1, // Select input 1
    output logic pair_select_in_2, // Select input 2
    output logic pair_select_in_3, // Select input 3
    output logic pair_select_in_4 // Select input 4
);
    logic [3:0] code_r = 4'h0;
    logic [1:0] gap_r = 2'h0;
    logic [3:0] diff;
    assign diff = code_r ^ code_want;
    assign {pair_select_in_1, pair_select_in_2, pair_select_in_3, pair_select_in_4} = code_r;
    // Slow steps leave short invalid codes on the wires, as real relays do
    always @(posedge pclk)
    begin
        gap_r <= gap_r + 2'h1;
        if (!slow)
            code_r <= code_want;
        else if (gap_r == 2'h3)
            code_r <= code_r ^ (diff & (~diff + 4'h1));
    end
endmodule : select_ctrl_model
